// ### rtl/sdi_out_consts.vh
`ifndef SDI_OUT_CONSTS_VH
`define SDI_OUT_CONSTS_VH
// Control word fields.
`define CTL_ENABLE 0
`define CTL_FRAME 4
`define CTL_DETECT 5
`define CTL_EDH_CLR 6
`define CTL_MASK_LSB 8
`define CTL_MASK_MSB 13
`define CTL_FORCE_LSB 16
`define CTL_FORCE_MSB 18
`define CTL_EDHEN_LSB 32
`define CTL_EDHEN_MSB 47
// Mode codes.
`define MODE_HD 3'h0
`define MODE_SD 3'h1
`define MODE_3G 3'h2
`define MODE_6G 3'h4
`define MODE_12G 3'h5
`define MODE_12GF 3'h6
// Timing reference words.
`define TRS_FIRST 10'h3ff
`define TRS_ZERO 10'h000
`define XYZ_H_BIT 6
`define TRS_TAIL 2'h3
`define FAMILY_UNKNOWN 4'hf
`define RATE_NONE 4'h0
// Register byte addresses and configuration bits.
`define ADR_CFG 8'h00
`define ADR_STATUS 8'h04
`define ADR_CRC 8'h08
`define ADR_EDH 8'h0c
`define CFG_SDI 0
`define CFG_ANC 1
`define CFG_PID 2
`define CFG_SIXTEEN 3
`define CFG_VIDEO 4
`define CFG_RESET 5'h05
`define MODE_DWELL 16'h0100
`endif

// ### rtl/mode_hunt.v
`timescale 1ns/1ps
`include "sdi_out_consts.vh"
module mode_hunt #(
   parameter [15:0] DWELL = `MODE_DWELL
) (
   input wire clk,
   input wire rst_n,
   input wire enable,
   input wire detect_en,
   input wire [5:0] mode_mask,
   input wire [2:0] forced_mode,
   input wire match,
   output wire [2:0] mode,
   output wire locked
);
   reg [2:0] idx_reg;
   reg [2:0] idx_next;
   reg [15:0] cnt_reg;
   reg locked_reg;
   reg found;
   reg [31:0] cand;
   integer k;

   function [2:0] mask_code;
      input [2:0] idx;
      begin
         case (idx)
            3'h0: mask_code = `MODE_HD;
            3'h1: mask_code = `MODE_SD;
            3'h2: mask_code = `MODE_3G;
            3'h3: mask_code = `MODE_6G;
            3'h4: mask_code = `MODE_12G;
            default: mask_code = `MODE_12GF;
         endcase
      end
   endfunction

   // Next permitted mode after the current one, wrapping round.
   always @* begin
      idx_next = idx_reg;
      found = 1'b0;
      cand = 32'h00000000;
      for (k = 1; k <= 6; k = k + 1) begin
         cand = (idx_reg + k) % 6;
         if (!found && mode_mask[cand[2:0]]) begin
            idx_next = cand[2:0];
            found = 1'b1;
         end
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idx_reg <= 3'h0;
         cnt_reg <= 16'h0000;
         locked_reg <= 1'b0;
      end else if (!enable) begin
         locked_reg <= 1'b0;
         cnt_reg <= 16'h0000;
      end else if (!detect_en) begin
         locked_reg <= match;
      end else if (locked_reg) begin
         locked_reg <= match;
         cnt_reg <= 16'h0000;
      end else if (match) begin
         locked_reg <= 1'b1;
      end else if (cnt_reg == DWELL - 16'h0001) begin
         cnt_reg <= 16'h0000;
         idx_reg <= idx_next;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   assign mode = detect_en ? mask_code(idx_reg) : forced_mode;
   assign locked = locked_reg;
endmodule // mode_hunt

// ### rtl/edh_err_counter.v
`timescale 1ns/1ps
module edh_err_counter #(
   parameter W = 16
) (
   input wire clk,
   input wire rst_n,
   input wire clear,
   input wire [15:0] mask,
   input wire [15:0] err,
   output wire [W-1:0] count
);
   reg [W-1:0] count_reg;

   // The counter saturates so software never sees a wrap to a small value.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= {W{1'b0}};
      end else if (clear) begin
         count_reg <= {W{1'b0}};
      end else if (|(err & mask) && !(&count_reg)) begin
         count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
      end
   end

   assign count = count_reg;
endmodule // edh_err_counter

// ### rtl/sdi_rx_native_out.v
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "sdi_out_consts.vh"
module sdi_rx_native_out #(
   parameter BPC = 10,
   parameter PPC = 2,
   parameter VID_W = BPC * PPC * 3
) (
   input wire MCLK,
   input wire NRST,
   input wire [63:0] SDI_RX_CTRL,
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [7:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   output reg [31:0] WB_DAT_O,
   output reg WB_ACK_O,
   input wire CORE_CE_IN,
   input wire [159:0] CORE_WORD_IN,
   input wire [175:0] CORE_LINE_IN,
   input wire CORE_MATCH_IN,
   input wire [2:0] CORE_ACTIVE_IN,
   input wire CORE_LEVEL_B_IN,
   input wire [15:0] CORE_CRC_IN,
   input wire [15:0] CORE_EDH_IN,
   input wire CORE_T_LOCKED_IN,
   input wire [3:0] CORE_T_FAMILY_IN,
   input wire [3:0] CORE_T_RATE_IN,
   input wire CORE_T_SCAN_IN,
   input wire CORE_RESET_IN,
   input wire [255:0] PID_Y_IN,
   input wire [7:0] PID_Y_OK_IN,
   input wire [255:0] PID_C_IN,
   input wire [7:0] PID_C_OK_IN,
   input wire [VID_W-1:0] VID_DATA_IN,
   input wire VID_ACTIVE_IN,
   input wire VID_HBLANK_IN,
   input wire VID_VBLANK_IN,
   input wire VID_FIELD_IN,
   output reg CORE_ENABLE,
   output reg CORE_FRAME_EN,
   output reg CORE_DETECT_EN,
   output reg [79:0] STREAM_WORD,
   output reg [87:0] STREAM_LINE_INDEX,
   output reg CE_OUT,
   output reg [2:0] ACTIVE_STREAMS,
   output reg MODE_LOCKED,
   output reg EAV_FLAG,
   output reg SAV_FLAG,
   output reg TRS_FLAG,
   output reg LOCKED_HD_FLAG,
   output reg LOCKED_SD_FLAG,
   output reg LOCKED_3G_FLAG,
   output reg LOCKED_6G_FLAG,
   output reg LOCKED_12G_FLAG,
   output reg LEVEL_B_INDICATOR,
   output reg [2:0] MODE_CODE,
   output reg [31:0] RX_ERR,
   output reg [255:0] PAYLOAD_ID_WORD,
   output reg [7:0] PAYLOAD_ID_OK,
   output reg [255:0] PAYLOAD_ID_C_WORD,
   output reg [7:0] PAYLOAD_ID_C_OK,
   output reg [VID_W-1:0] PIXEL_DATA,
   output reg PIXEL_ACTIVE_QUALIFIER,
   output reg HORIZ_BLANK,
   output reg VERT_BLANK,
   output reg FIELD_OUT,
   output reg [159:0] ANC_WORD,
   output reg [31:0] ANC_CTRL
);
   reg rst_meta_reg;
   reg rst_n_reg;
   reg [4:0] cfg_reg;
   reg [159:0] w0_reg;
   reg [159:0] w1_reg;
   reg [159:0] w2_reg;
   reg [175:0] l0_reg;
   reg [175:0] l1_reg;
   reg [175:0] l2_reg;
   reg [1:0] trs_cnt_reg;
   reg trs_h_reg;
   wire [2:0] hunt_mode;
   wire hunt_locked;
   wire [15:0] edh_count;
   wire cfg_sdi;
   wire cfg_anc;
   wire cfg_pid;
   wire cfg_16;
   wire cfg_vid;
   wire trs_match;
   wire wb_hit;
   wire [159:0] hi_mask;
   wire [255:0] pid_mask;
   wire level_a_3g;

   function is_mode;
      input [2:0] have;
      input [2:0] want;
      begin
         is_mode = (have == want);
      end
   endfunction

   // The asynchronous assert is kept, but release is timed to MCLK.
   always @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   assign cfg_sdi = cfg_reg[`CFG_SDI];
   assign cfg_anc = cfg_reg[`CFG_ANC];
   assign cfg_pid = cfg_reg[`CFG_PID];
   assign cfg_16 = cfg_reg[`CFG_SIXTEEN];
   assign cfg_vid = cfg_reg[`CFG_VIDEO];
   assign hi_mask = {{80{cfg_16}}, {80{1'b1}}};
   assign pid_mask = {{128{cfg_16}}, {128{1'b1}}};

   mode_hunt #(
      .DWELL(`MODE_DWELL)
   ) u_hunt (
      .clk(MCLK),
      .rst_n(rst_n_reg),
      .enable(SDI_RX_CTRL[`CTL_ENABLE]),
      .detect_en(SDI_RX_CTRL[`CTL_DETECT]),
      .mode_mask(SDI_RX_CTRL[`CTL_MASK_MSB:`CTL_MASK_LSB]),
      .forced_mode(SDI_RX_CTRL[`CTL_FORCE_MSB:`CTL_FORCE_LSB]),
      .match(CORE_MATCH_IN),
      .mode(hunt_mode),
      .locked(hunt_locked)
   );

   edh_err_counter #(
      .W(16)
   ) u_edh (
      .clk(MCLK),
      .rst_n(rst_n_reg),
      .clear(SDI_RX_CTRL[`CTL_EDH_CLR]),
      .mask(SDI_RX_CTRL[`CTL_EDHEN_MSB:`CTL_EDHEN_LSB]),
      .err(CORE_EDH_IN),
      .count(edh_count)
   );

   // Control bits for the receiver core; reserved bits are never looked at.
   always @(posedge MCLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         CORE_ENABLE <= 1'b0;
         CORE_FRAME_EN <= 1'b0;
         CORE_DETECT_EN <= 1'b0;
      end else begin
         CORE_ENABLE <= SDI_RX_CTRL[`CTL_ENABLE];
         CORE_FRAME_EN <= SDI_RX_CTRL[`CTL_FRAME];
         CORE_DETECT_EN <= SDI_RX_CTRL[`CTL_DETECT];
      end
   end

   // Register bus: one wait state, unmapped reads return zero.
   assign wb_hit = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   always @(posedge MCLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h00000000;
         cfg_reg <= `CFG_RESET;
      end else begin
         WB_ACK_O <= wb_hit;
         WB_DAT_O <= 32'h00000000;
         if (wb_hit && WB_WE_I && WB_ADR_I == `ADR_CFG && WB_SEL_I[0]) begin
            cfg_reg <= WB_DAT_I[4:0];
         end
         if (wb_hit && !WB_WE_I) begin
            case (WB_ADR_I)
               `ADR_CFG: WB_DAT_O <= {27'h0000000, cfg_reg};
               `ADR_STATUS: WB_DAT_O <= {23'h000000, CORE_T_LOCKED_IN,
                  CORE_LEVEL_B_IN, ACTIVE_STREAMS, hunt_locked, hunt_mode};
               `ADR_CRC: WB_DAT_O <= {16'h0000, CORE_CRC_IN};
               `ADR_EDH: WB_DAT_O <= {16'h0000, edh_count};
               default: WB_DAT_O <= 32'h00000000;
            endcase
         end
      end
   end

   // Three words of look-ahead let the flag rise on the 3FF word itself.
   assign trs_match = (w2_reg[9:0] == `TRS_FIRST) && (w1_reg[9:0] == `TRS_ZERO) &&
      (w0_reg[9:0] == `TRS_ZERO) && CORE_WORD_IN[9];

   always @(posedge MCLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         w0_reg <= 160'h0;
         w1_reg <= 160'h0;
         w2_reg <= 160'h0;
         l0_reg <= 176'h0;
         l1_reg <= 176'h0;
         l2_reg <= 176'h0;
         trs_cnt_reg <= 2'h0;
         trs_h_reg <= 1'b0;
      end else if (CORE_CE_IN) begin
         w0_reg <= CORE_WORD_IN;
         w1_reg <= w0_reg;
         w2_reg <= w1_reg;
         l0_reg <= CORE_LINE_IN;
         l1_reg <= l0_reg;
         l2_reg <= l1_reg;
         if (trs_match) begin
            trs_cnt_reg <= `TRS_TAIL;
            trs_h_reg <= CORE_WORD_IN[`XYZ_H_BIT];
         end else if (trs_cnt_reg != 2'h0) begin
            trs_cnt_reg <= trs_cnt_reg - 2'h1;
         end
      end
   end

   // Native stream port; words and flags hold between clock enables, CE_OUT and ACTIVE_STREAMS update every cycle.
   always @(posedge MCLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         STREAM_WORD <= 80'h0;
         STREAM_LINE_INDEX <= 88'h0;
         CE_OUT <= 1'b0;
         TRS_FLAG <= 1'b0;
         EAV_FLAG <= 1'b0;
         SAV_FLAG <= 1'b0;
         ACTIVE_STREAMS <= 3'h0;
         ANC_WORD <= 160'h0;
      end else begin
         CE_OUT <= cfg_sdi && CORE_CE_IN;
         ACTIVE_STREAMS <= cfg_sdi ? CORE_ACTIVE_IN : 3'h0;
         if (CORE_CE_IN) begin
            STREAM_WORD <= cfg_sdi ? w2_reg[79:0] : 80'h0;
            STREAM_LINE_INDEX <= cfg_sdi ? l2_reg[87:0] : 88'h0;
            ANC_WORD <= cfg_anc ? (w2_reg & hi_mask) : 160'h0;
            TRS_FLAG <= cfg_sdi && (trs_match || trs_cnt_reg != 2'h0);
            EAV_FLAG <= cfg_sdi && trs_cnt_reg == 2'h1 && trs_h_reg;
            SAV_FLAG <= cfg_sdi && trs_cnt_reg == 2'h1 && !trs_h_reg;
         end
      end
   end

   // Status, mode flags and error word.
   always @(posedge MCLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         MODE_LOCKED <= 1'b0;
         MODE_CODE <= `MODE_HD;
         LOCKED_HD_FLAG <= 1'b0;
         LOCKED_SD_FLAG <= 1'b0;
         LOCKED_3G_FLAG <= 1'b0;
         LOCKED_6G_FLAG <= 1'b0;
         LOCKED_12G_FLAG <= 1'b0;
         LEVEL_B_INDICATOR <= 1'b0;
         RX_ERR <= 32'h00000000;
      end else begin
         MODE_LOCKED <= cfg_sdi && hunt_locked;
         MODE_CODE <= cfg_sdi ? hunt_mode : `MODE_HD;
         LOCKED_HD_FLAG <= cfg_sdi && hunt_locked && is_mode(hunt_mode, `MODE_HD);
         LOCKED_SD_FLAG <= cfg_sdi && hunt_locked && is_mode(hunt_mode, `MODE_SD);
         LOCKED_3G_FLAG <= cfg_sdi && hunt_locked && is_mode(hunt_mode, `MODE_3G);
         LOCKED_6G_FLAG <= cfg_sdi && hunt_locked && is_mode(hunt_mode, `MODE_6G);
         LOCKED_12G_FLAG <= cfg_sdi && hunt_locked && (is_mode(hunt_mode, `MODE_12G) ||
            is_mode(hunt_mode, `MODE_12GF));
         LEVEL_B_INDICATOR <= cfg_sdi && hunt_locked && is_mode(hunt_mode, `MODE_3G) &&
            CORE_LEVEL_B_IN;
         RX_ERR <= cfg_sdi ? {16'h0000, CORE_CRC_IN} : 32'h00000000;
      end
   end

   // Payload ID words; in 3G level A the C word's entry 1 is taken from the Y word.
   assign level_a_3g = hunt_locked && is_mode(hunt_mode, `MODE_3G) && !CORE_LEVEL_B_IN;
   always @(posedge MCLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         PAYLOAD_ID_WORD <= 256'h0;
         PAYLOAD_ID_OK <= 8'h00;
         PAYLOAD_ID_C_WORD <= 256'h0;
         PAYLOAD_ID_C_OK <= 8'h00;
      end else if (cfg_pid && cfg_sdi) begin
         PAYLOAD_ID_WORD <= PID_Y_IN & pid_mask;
         PAYLOAD_ID_OK <= PID_Y_OK_IN & {{4{cfg_16}}, 4'hf};
         PAYLOAD_ID_C_WORD <= PID_C_IN & pid_mask;
         PAYLOAD_ID_C_OK <= PID_C_OK_IN & {{4{cfg_16}}, 4'hf};
         if (level_a_3g) begin
            PAYLOAD_ID_C_WORD[63:32] <= PID_Y_IN[63:32];
            PAYLOAD_ID_C_OK[1] <= PID_Y_OK_IN[1];
         end
      end else begin
         PAYLOAD_ID_WORD <= 256'h0;
         PAYLOAD_ID_OK <= 8'h00;
         PAYLOAD_ID_C_WORD <= 256'h0;
         PAYLOAD_ID_C_OK <= 8'h00;
      end
   end

   // Native video port and ancillary control word.
   always @(posedge MCLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         PIXEL_DATA <= {VID_W{1'b0}};
         PIXEL_ACTIVE_QUALIFIER <= 1'b0;
         HORIZ_BLANK <= 1'b0;
         VERT_BLANK <= 1'b0;
         FIELD_OUT <= 1'b0;
         ANC_CTRL <= 32'h00000000;
      end else begin
         PIXEL_DATA <= cfg_vid ? VID_DATA_IN : {VID_W{1'b0}};
         PIXEL_ACTIVE_QUALIFIER <= cfg_vid && VID_ACTIVE_IN;
         HORIZ_BLANK <= cfg_vid && VID_HBLANK_IN;
         VERT_BLANK <= cfg_vid && VID_VBLANK_IN;
         // Segmented frames ride an interlaced transport, so they still toggle.
         FIELD_OUT <= cfg_vid && VID_FIELD_IN && !CORE_T_SCAN_IN;
         if (cfg_anc) begin
            ANC_CTRL <= {16'h0000, CORE_RESET_IN,
               CORE_T_LOCKED_IN && CORE_T_SCAN_IN,
               CORE_T_LOCKED_IN ? CORE_T_RATE_IN : `RATE_NONE,
               CORE_T_LOCKED_IN, hunt_locked,
               CORE_T_LOCKED_IN ? CORE_T_FAMILY_IN : `FAMILY_UNKNOWN,
               hunt_mode, CORE_CE_IN};
         end else begin
            ANC_CTRL <= 32'h00000000;
         end
      end
   end
endmodule // sdi_rx_native_out

// ### tb/sdi_rx_native_out_assertions.sv
`timescale 1ns/1ps
`include "sdi_out_consts.vh"
module sdi_rx_native_out_checker (
   input wire MCLK,
   input wire NRST,
   input wire [63:0] SDI_RX_CTRL,
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_ACK_O,
   input wire CORE_CE_IN,
   input wire CE_OUT,
   input wire CORE_ENABLE,
   input wire CORE_FRAME_EN,
   input wire CORE_DETECT_EN,
   input wire [79:0] STREAM_WORD,
   input wire TRS_FLAG,
   input wire EAV_FLAG,
   input wire SAV_FLAG,
   input wire MODE_LOCKED,
   input wire [2:0] MODE_CODE,
   input wire LOCKED_HD_FLAG,
   input wire LOCKED_SD_FLAG,
   input wire LOCKED_3G_FLAG,
   input wire LOCKED_6G_FLAG,
   input wire LOCKED_12G_FLAG,
   input wire [31:0] RX_ERR,
   input wire [15:0] CORE_CRC_IN,
   input wire [31:0] ANC_CTRL
);
   // The internal reset trails NRST by two flops, so settle first.
   reg [2:0] up_reg;
   always @(posedge MCLK or negedge NRST) begin
      if (!NRST) up_reg <= 3'h0;
      else if (up_reg != 3'h7) up_reg <= up_reg + 3'h1;
   end
   wire any_mode = LOCKED_HD_FLAG | LOCKED_SD_FLAG | LOCKED_3G_FLAG | LOCKED_6G_FLAG
      | LOCKED_12G_FLAG;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!NRST);
   property p_ctrl;
      (up_reg == 3'h7) |-> {CORE_ENABLE, CORE_FRAME_EN, CORE_DETECT_EN} ==
         {$past(SDI_RX_CTRL[0]), $past(SDI_RX_CTRL[4]), $past(SDI_RX_CTRL[5])};
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("control bits not forwarded");
   property p_ce;
      CE_OUT |-> $past(CORE_CE_IN);
   endproperty
   a_ce: assert property (p_ce) else $error("clock enable without word");
   property p_eav;
      EAV_FLAG |-> TRS_FLAG && STREAM_WORD[9] && STREAM_WORD[`XYZ_H_BIT];
   endproperty
   a_eav: assert property (p_eav) else $error("end flag off its word");
   property p_sav;
      SAV_FLAG |-> TRS_FLAG && STREAM_WORD[9] && !STREAM_WORD[`XYZ_H_BIT] && !EAV_FLAG;
   endproperty
   a_sav: assert property (p_sav) else $error("start flag off its word");
   property p_trs;
      $rose(TRS_FLAG) |-> STREAM_WORD[9:0] == `TRS_FIRST;
   endproperty
   a_trs: assert property (p_trs) else $error("reference flag not on first word");
   property p_unlock;
      !MODE_LOCKED |-> !any_mode;
   endproperty
   a_unlock: assert property (p_unlock) else $error("mode flag while unlocked");
   property p_hd;
      LOCKED_HD_FLAG |-> MODE_CODE == `MODE_HD && !LOCKED_SD_FLAG && !LOCKED_3G_FLAG;
   endproperty
   a_hd: assert property (p_hd) else $error("hd flag against mode");
   property p_3g;
      LOCKED_3G_FLAG |-> MODE_CODE == `MODE_3G && MODE_LOCKED;
   endproperty
   a_3g: assert property (p_3g) else $error("3g flag against mode");
   property p_err;
      RX_ERR[31:16] == 16'h0000 && (RX_ERR[15:0] == 16'h0000 ||
         RX_ERR[15:0] == $past(CORE_CRC_IN));
   endproperty
   a_err: assert property (p_err) else $error("error word wrong");
   property p_ack;
      (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O;
   endproperty
   a_ack: assert property (p_ack) else $error("bus answer not one pulse");
   property p_anc;
      ANC_CTRL[31:16] == 16'h0000;
   endproperty
   a_anc: assert property (p_anc) else $error("reserved ancillary bits set");
   c_eav: cover property (EAV_FLAG);
   c_sav: cover property (SAV_FLAG);
   c_lock: cover property ($rose(MODE_LOCKED));
   c_ack: cover property (WB_ACK_O);
endmodule // sdi_rx_native_out_checker

// ### tb/video_sink_model.sv
`timescale 1ns/1ps
module video_sink_model (
   input wire clk,
   input wire clr,
   input wire ce,
   input wire [9:0] word,
   input wire trs,
   input wire eav,
   input wire sav,
   output reg [3:0] trs_cnt,
   output reg [3:0] eav_cnt,
   output reg [3:0] sav_cnt,
   output reg [9:0] xyz_word
);
   // Words between enables are stale, so they are never looked at.
   always @(posedge clk) begin
      if (clr) begin
         trs_cnt <= 4'h0;
         eav_cnt <= 4'h0;
         sav_cnt <= 4'h0;
         xyz_word <= 10'h000;
      end else if (ce) begin
         if (trs) trs_cnt <= trs_cnt + 4'h1;
         if (sav) sav_cnt <= sav_cnt + 4'h1;
         if (eav) begin
            eav_cnt <= eav_cnt + 4'h1;
            xyz_word <= word;
         end
      end
   end
endmodule // video_sink_model

// ### tb/tb_sdi_rx_native_output_port.sv
`timescale 1ns/1ps
`include "sdi_out_consts.vh"
module tb_sdi_rx_native_output_port;
   logic clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, ce = 0, match = 0, lvlb = 0, sclr = 1;
   logic tlk = 0, scan = 0, crst = 0, vact = 0, hb = 0, vb = 0, fld = 0;
   logic [63:0] ctrl = 0;
   logic [7:0] adr = 0, pidyok = 0, pidcok = 0;
   logic [3:0] sel = 0, fam = 0, rate = 0;
   logic [31:0] wdat = 0, q;
   logic [159:0] word = 0;
   logic [175:0] line = {16{11'h2a5}};
   logic [2:0] act = 0;
   logic [15:0] crc = 0, edh = 0;
   logic [255:0] pidy = {8{32'h1234_5678}}, pidc = {8{32'hcafe_0042}};
   logic [59:0] vdat = 60'h0ab_cdef_0123_4567;
   wire [31:0] rdat, err, anc_ctrl;
   wire ack, ce_o, lock, eav, sav, trs, hd, sd, g3, g6, g12, lb, pq, hbo, vbo, fo;
   wire [79:0] sw;
   wire [87:0] sli;
   wire [2:0] mcode, astr;
   wire [255:0] pw, pcw;
   wire [7:0] pok, pcok;
   wire [59:0] pix;
   wire [159:0] anc;
   wire [3:0] trs_cnt, eav_cnt, sav_cnt;
   wire [9:0] xyz;
   integer fails = 0, n_tests = 0, i;
   always #4 clk = ~clk;
   sdi_rx_native_out uut (.MCLK(clk), .NRST(nrst), .SDI_RX_CTRL(ctrl), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
      .WB_DAT_O(rdat), .WB_ACK_O(ack), .CORE_CE_IN(ce), .CORE_WORD_IN(word), .CORE_LINE_IN(line),
      .CORE_MATCH_IN(match), .CORE_ACTIVE_IN(act), .CORE_LEVEL_B_IN(lvlb), .CORE_CRC_IN(crc),
      .CORE_EDH_IN(edh), .CORE_T_LOCKED_IN(tlk), .CORE_T_FAMILY_IN(fam), .CORE_T_RATE_IN(rate),
      .CORE_T_SCAN_IN(scan), .CORE_RESET_IN(crst), .PID_Y_IN(pidy), .PID_Y_OK_IN(pidyok),
      .PID_C_IN(pidc), .PID_C_OK_IN(pidcok), .VID_DATA_IN(vdat), .VID_ACTIVE_IN(vact),
      .VID_HBLANK_IN(hb), .VID_VBLANK_IN(vb), .VID_FIELD_IN(fld), .CORE_ENABLE(),
      .CORE_FRAME_EN(), .CORE_DETECT_EN(), .STREAM_WORD(sw), .STREAM_LINE_INDEX(sli),
      .CE_OUT(ce_o), .ACTIVE_STREAMS(astr), .MODE_LOCKED(lock), .EAV_FLAG(eav), .SAV_FLAG(sav),
      .TRS_FLAG(trs), .LOCKED_HD_FLAG(hd), .LOCKED_SD_FLAG(sd), .LOCKED_3G_FLAG(g3),
      .LOCKED_6G_FLAG(g6), .LOCKED_12G_FLAG(g12), .LEVEL_B_INDICATOR(lb), .MODE_CODE(mcode),
      .RX_ERR(err), .PAYLOAD_ID_WORD(pw), .PAYLOAD_ID_OK(pok), .PAYLOAD_ID_C_WORD(pcw),
      .PAYLOAD_ID_C_OK(pcok), .PIXEL_DATA(pix), .PIXEL_ACTIVE_QUALIFIER(pq), .HORIZ_BLANK(hbo),
      .VERT_BLANK(vbo), .FIELD_OUT(fo), .ANC_WORD(anc), .ANC_CTRL(anc_ctrl));
   video_sink_model sink (.clk(clk), .clr(sclr), .ce(ce_o), .word(sw[9:0]), .trs(trs),
      .eav(eav), .sav(sav), .trs_cnt(trs_cnt), .eav_cnt(eav_cnt), .sav_cnt(sav_cnt),
      .xyz_word(xyz));
   task chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Read data is taken at the edge that samples ack high; the watchdog ends a hang.
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask
   task send(input logic [9:0] w);
      @(posedge clk);
      ce <= 1'b1;
      word <= {{15{10'h155}}, w};
      @(posedge clk);
      ce <= 1'b0;
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
   logic [4:0] flags [6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h01};
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      wb(0, `ADR_CFG, 0); chk(q, `CFG_RESET);
      wb(1, `ADR_CFG, 32'h1f); wb(0, `ADR_CFG, 0); chk(q, 32'h1f);
      wb(0, 8'h40, 0); chk(q, 0);
      $display("test registers done");
      match <= 1'b1;
      for (i = 0; i < 6; i++) begin
         ctrl <= {45'h0, modes[i], 16'h0001};
         repeat (4) @(posedge clk);
         chk(mcode, modes[i]);
         chk({hd, sd, g3, g6, g12, lock}, {flags[i], 1'b1});
      end
      match <= 1'b0;
      repeat (4) @(posedge clk);
      chk({lock, hd, sd, g3, g6, g12}, 0);
      ctrl <= 64'h0221;
      repeat (600) @(posedge clk);
      chk(lock, 0);
      match <= 1'b1;
      for (i = 0; i < 700 && lock !== 1'b1; i++) @(posedge clk);
      chk({lock, mcode, sd}, {1'b1, `MODE_SD, 1'b1});
      $display("test modes done");
      ctrl <= {45'h0, `MODE_3G, 16'h0001};
      pidyok <= 8'hff;
      repeat (4) @(posedge clk);
      chk(lb, 0);
      chk({pcw[63:32], pw[31:0]}, {pidy[63:32], pidy[31:0]});
      chk(pw[159:128], pidy[159:128]);
      chk({pok, pcok}, {8'hff, 8'h02});
      lvlb <= 1'b1;
      act <= 3'h3;
      repeat (4) @(posedge clk);
      chk({lb, astr, pcw[63:32]}, {1'b1, 3'h3, pidc[63:32]});
      wb(0, `ADR_STATUS, 0); chk(q, 32'h0ba);
      wb(1, `ADR_CFG, 32'h07);
      repeat (3) @(posedge clk);
      chk({pw[159:128], pw[31:0]}, {32'h0, pidy[31:0]});
      chk({pok, pcok}, {8'h0f, 8'h00});
      wb(1, `ADR_CFG, 32'h1f);
      $display("test payload done");
      crc <= 16'h8001; tlk <= 1'b1; rate <= 4'hb; scan <= 1'b1;
      repeat (3) @(posedge clk);
      chk(err, 32'h8001);
      chk(anc_ctrl, 32'h6f04);
      tlk <= 1'b0;
      repeat (3) @(posedge clk);
      chk(anc_ctrl, 32'h01f4);
      fld <= 1'b1; vact <= 1'b1; vb <= 1'b1; scan <= 1'b0;
      repeat (3) @(posedge clk);
      chk({pix, pq, hbo, vbo, fo}, {vdat, 4'hb});
      scan <= 1'b1;
      repeat (3) @(posedge clk);
      chk(fo, 0);
      $display("test status done");
      sclr <= 1'b0;
      // Four trailing words push the second reference's XYZ word out of the pipeline.
      for (i = 0; i < 20; i++)
         send(i % 9 == 3 ? 10'h3ff : i % 9 == 6 ? (i < 9 ? 10'h274 : 10'h200)
            : i % 9 > 3 && i % 9 < 6 ? 10'h000 : 10'h1a0);
      repeat (2) @(posedge clk);
      chk({trs_cnt, eav_cnt, sav_cnt, xyz}, {4'h8, 4'h1, 4'h1, 10'h274});
      chk(sw[79:40], {4{10'h155}});
      chk({sw[39:10], sli[10:0]}, {{3{10'h155}}, 11'h2a5});
      chk(anc[159:150], 10'h155);
      $display("test streams done");
      ctrl <= 64'h0000_0001_0002_0001;
      for (i = 0; i < 5; i++) begin
         @(posedge clk);
         edh <= i < 3 ? 16'h0001 : 16'h0002;
         @(posedge clk);
         edh <= 16'h0000;
      end
      repeat (3) @(posedge clk);
      wb(0, `ADR_EDH, 0); chk(q, 32'h3);
      ctrl <= 64'h0000_0001_0002_0041;
      repeat (3) @(posedge clk);
      ctrl <= 64'h0000_0001_0002_0001;
      wb(0, `ADR_EDH, 0); chk(q, 32'h0);
      $display("test error count done");
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      report_and_stop;
   end
endmodule // tb_sdi_rx_native_output_port
bind sdi_rx_native_out sdi_rx_native_out_checker chk_i (.MCLK, .NRST, .SDI_RX_CTRL, .WB_CYC_I,
   .WB_STB_I, .WB_ACK_O, .CORE_CE_IN, .CE_OUT, .CORE_ENABLE, .CORE_FRAME_EN, .CORE_DETECT_EN,
   .STREAM_WORD, .TRS_FLAG, .EAV_FLAG, .SAV_FLAG, .MODE_LOCKED, .MODE_CODE, .LOCKED_HD_FLAG,
   .LOCKED_SD_FLAG, .LOCKED_3G_FLAG, .LOCKED_6G_FLAG, .LOCKED_12G_FLAG, .RX_ERR, .CORE_CRC_IN,
   .ANC_CTRL);
